/* src/adc_result_window_detector.sv */
// Converter control, result formatting and window detector with AXI4-Lite.
//
// Overview of operation
// - Justify bit picks right or left placement.
// - Left justified high byte holds upper eight.
// - Every result taken while busy compared against limits, system notified.
// - Window match flag is readable for polling.
// - Limit order selects inside or outside match.
// - Less-than word is high byte then low.
// - Less-than high byte is read/write register.
// - Less-than low byte read/write, resets zero.
// - Enable low keeps converter in shutdown.
// - Track mode zero tracks except while converting.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "adc_window_regs.svh"

module adc_result_window_detector (
    input wire logic aclk, // System clock, 250 MHz.
    input wire logic aresetn, // Synchronous reset, active low.
    // AXI4-Lite write address channel.
    input wire logic [11:0] s_axi_awaddr, // Write byte address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    // AXI4-Lite write data channel.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    // AXI4-Lite write response channel.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    // AXI4-Lite read address channel.
    input wire logic [11:0] s_axi_araddr, // Read byte address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    // AXI4-Lite read data channel.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    // Converter side.
    input adc_window_pkg::conv_result_t conv_result, // Finished result.
    output adc_window_pkg::conv_ctrl_t conv_ctrl, // Converter control.
    output logic irq // Level interrupt request.
);

    // Converter control register fields.
    logic converter_enable; // Converter powered up when set.
    logic track_mode; // Zero tracks continuously between conversions.
    logic conversion_done_flag; // Sticky conversion complete flag.
    logic conversion_busy; // Conversion under way.
    logic [1:0] start_mode_select; // Start source select, stored only.
    logic window_match_flag; // Sticky window match flag.
    logic justify_select; // Zero right, one left justify.

    // Data and limit registers.
    logic [7:0] result_high_byte; // Formatted result, upper byte.
    logic [7:0] result_low_byte; // Formatted result, lower byte.
    logic [7:0] greater_than_word_high; // Greater-than limit, upper byte.
    logic [7:0] greater_than_word_low; // Greater-than limit, lower byte.
    logic [7:0] less_than_word_high; // Less-than limit, upper byte.
    logic [7:0] less_than_word_low; // Less-than limit, lower byte.
    logic [1:0] irq_mask; // Interrupt enables per event.
    logic start_pulse; // Registered one-cycle conversion request.

    // Write channel holding state.
    logic aw_held; // Write address captured.
    logic w_held; // Write data captured.
    logic [11:0] wr_addr; // Captured write address.
    logic [7:0] wr_byte; // Captured low data byte.
    logic wr_lane; // Captured strobe for the low byte.

    // Comparator results.
    adc_window_pkg::data_word_t fmt_word; // Formatted incoming result.
    logic window_hit; // Incoming result inside selected region.
    logic [15:0] gt_word; // Greater-than limit word.
    logic [15:0] lt_word; // Less-than limit word.

    // Decoded write strobes.
    logic do_write; // A write is carried out this cycle.
    logic wr_mapped; // Write address hits the register window.
    logic [7:0] wr_index; // Register index of the write.
    logic wr_ctrl; // Write to the control register.
    logic wr_status; // Write to the interrupt status register.
    logic start_req; // Software asked for a conversion.
    logic done_evt; // A result arrives this cycle.
    logic [7:0] rd_index; // Register index of the read.
    logic [7:0] rd_byte; // Selected read data.
    logic rd_hit; // Read address is mapped.

    // Limit words are formed from their byte registers, high byte on top.
    assign gt_word = {greater_than_word_high, greater_than_word_low};
    assign lt_word = {less_than_word_high, less_than_word_low};

    // Results are only accepted while a conversion is pending.
    assign done_evt = conv_result.valid && conversion_busy;

    // One comparator looks at each result as it arrives.
    adc_window_compare adc_window_compare_i (
        .raw(conv_result.data),
        .justify(justify_select),
        .gt_word(gt_word),
        .lt_word(lt_word),
        .word(fmt_word),
        .match(window_hit)
    );

    // Write decode. Only byte lane zero carries register data.
    always_comb begin
        do_write = aw_held && w_held && !s_axi_bvalid;
        wr_index = wr_addr[9:2];
        wr_mapped = (wr_addr[11:10] == 2'h0) && (wr_addr[1:0] == 2'h0);
        case (wr_index)
            `IDX_RESULT_LOW, `IDX_RESULT_HIGH, `IDX_GT_LOW, `IDX_GT_HIGH,
            `IDX_LT_LOW, `IDX_LT_HIGH, `IDX_CONTROL, `IDX_IRQ_STATUS,
            `IDX_IRQ_MASK: wr_mapped = wr_mapped;
            default: wr_mapped = 1'b0;
        endcase
        wr_ctrl = do_write && wr_lane && wr_mapped
            && (wr_index == `IDX_CONTROL);
        wr_status = do_write && wr_lane && wr_mapped
            && (wr_index == `IDX_IRQ_STATUS);
        start_req = wr_ctrl && wr_byte[`BIT_BUSY] && !conversion_busy
            && converter_enable && wr_byte[`BIT_ENABLE];
    end

    // Bus ready signals; each channel is taken once and then held.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Address and data may be taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 12'h000;
            wr_byte <= 8'h00;
            wr_lane <= 1'b0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wr_byte <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
            end
        end
    end

    // Write response; unmapped addresses answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Limit registers; software fills each byte on its own.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            greater_than_word_high <= `RST_GT_HIGH;
            greater_than_word_low <= `RST_GT_LOW;
            less_than_word_high <= `RST_LT_HIGH;
            less_than_word_low <= `RST_LT_LOW;
            irq_mask <= `RST_MASK;
        end else if (do_write && wr_lane && wr_mapped) begin
            case (wr_index)
                `IDX_GT_HIGH: greater_than_word_high <= wr_byte;
                `IDX_GT_LOW: greater_than_word_low <= wr_byte;
                `IDX_LT_HIGH: less_than_word_high <= wr_byte;
                `IDX_LT_LOW: less_than_word_low <= wr_byte;
                `IDX_IRQ_MASK: irq_mask <= wr_byte[1:0];
                default: irq_mask <= irq_mask;
            endcase
        end
    end

    // Plain control fields of the converter control register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_enable <= 1'b0;
            track_mode <= 1'b0;
            start_mode_select <= 2'h0;
            justify_select <= 1'b0;
        end else if (wr_ctrl) begin
            converter_enable <= wr_byte[`BIT_ENABLE];
            track_mode <= wr_byte[`BIT_TRACK_MODE];
            start_mode_select <= wr_byte[`BIT_START_HI:`BIT_START_LO];
            justify_select <= wr_byte[`BIT_JUSTIFY];
        end
    end

    // Busy is set by a software start and cleared when the result lands.
    // Disabling the converter drops a pending conversion.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conversion_busy <= 1'b0;
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= start_req;
            if (!converter_enable) begin
                conversion_busy <= 1'b0;
            end else if (start_req) begin
                conversion_busy <= 1'b1;
            end else if (done_evt) begin
                conversion_busy <= 1'b0;
            end
        end
    end

    // Result bytes take the formatted word; software may also write them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_high_byte <= `RST_BYTE;
            result_low_byte <= `RST_BYTE;
        end else if (done_evt) begin
            result_high_byte <= fmt_word.high;
            result_low_byte <= fmt_word.low;
        end else if (do_write && wr_lane && wr_mapped) begin
            if (wr_index == `IDX_RESULT_HIGH) begin
                result_high_byte <= wr_byte;
            end else if (wr_index == `IDX_RESULT_LOW) begin
                result_low_byte <= wr_byte;
            end
        end
    end

    // Sticky flags. Hardware only sets them, and a set in the same cycle
    // as a software clear wins so no event is lost. The control register
    // clears by writing zero, the status register by writing one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            window_match_flag <= 1'b0;
            conversion_done_flag <= 1'b0;
        end else begin
            if (done_evt && window_hit) begin
                window_match_flag <= 1'b1;
            end else if (wr_ctrl && !wr_byte[`BIT_WIN_FLAG]) begin
                window_match_flag <= 1'b0;
            end else if (wr_status && wr_byte[`IRQ_BIT_WIN]) begin
                window_match_flag <= 1'b0;
            end
            if (done_evt) begin
                conversion_done_flag <= 1'b1;
            end else if (wr_ctrl && !wr_byte[`BIT_DONE_FLAG]) begin
                conversion_done_flag <= 1'b0;
            end else if (wr_status && wr_byte[`IRQ_BIT_DONE]) begin
                conversion_done_flag <= 1'b0;
            end
        end
    end

    // Read mux; reserved bits and unmapped indices read zero.
    always_comb begin
        rd_index = s_axi_araddr[9:2];
        rd_hit = (s_axi_araddr[11:10] == 2'h0)
            && (s_axi_araddr[1:0] == 2'h0);
        rd_byte = 8'h00;
        case (rd_index)
            `IDX_RESULT_HIGH: rd_byte = result_high_byte;
            `IDX_RESULT_LOW: rd_byte = result_low_byte;
            `IDX_GT_HIGH: rd_byte = greater_than_word_high;
            `IDX_GT_LOW: rd_byte = greater_than_word_low;
            `IDX_LT_HIGH: rd_byte = less_than_word_high;
            `IDX_LT_LOW: rd_byte = less_than_word_low;
            `IDX_CONTROL: begin
                rd_byte = {converter_enable, track_mode,
                    conversion_done_flag, conversion_busy,
                    start_mode_select, window_match_flag,
                    justify_select};
            end
            `IDX_IRQ_STATUS: begin
                rd_byte = {6'h00, window_match_flag,
                    conversion_done_flag};
            end
            `IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read answer is registered one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_hit ? rd_byte : 8'h00};
            s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Converter control outputs. Tracking in mode zero is continuous
    // except during a conversion; mode one leaves the sample stage held.
    always_comb begin
        conv_ctrl.enable = converter_enable;
        conv_ctrl.track = converter_enable && !track_mode
            && !conversion_busy;
        conv_ctrl.start = start_pulse;
    end

    // One level interrupt from the unmasked sticky flags.
    assign irq = |({window_match_flag, conversion_done_flag}
        & irq_mask);

endmodule // adc_result_window_detector

/* src/adc_window_regs.svh */
// Register indices, field positions, reset values and bus codes.
`ifndef ADC_WINDOW_REGS_SVH
`define ADC_WINDOW_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_RESULT_LOW 8'hBE
`define IDX_RESULT_HIGH 8'hBF
`define IDX_GT_LOW 8'hC4
`define IDX_GT_HIGH 8'hC5
`define IDX_LT_LOW 8'hC6
`define IDX_LT_HIGH 8'hC7
`define IDX_CONTROL 8'hE8
`define IDX_IRQ_STATUS 8'hF0
`define IDX_IRQ_MASK 8'hF1

// Field positions in the converter control register.
`define BIT_JUSTIFY 0
`define BIT_WIN_FLAG 1
`define BIT_START_LO 2
`define BIT_START_HI 3
`define BIT_BUSY 4
`define BIT_DONE_FLAG 5
`define BIT_TRACK_MODE 6
`define BIT_ENABLE 7

// Field positions in the interrupt status and mask registers.
`define IRQ_BIT_DONE 0
`define IRQ_BIT_WIN 1

// Reset values.
`define RST_BYTE 8'h00
`define RST_GT_LOW 8'hFF
`define RST_GT_HIGH 8'hFF
`define RST_LT_LOW 8'h00
`define RST_LT_HIGH 8'h00
`define RST_MASK 2'h0

// Bus response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* src/adc_window_pkg.sv */
// Types shared by the converter control block and its comparator.
package adc_window_pkg;

    // One conversion result delivered by the analog converter.
    typedef struct packed {
        logic valid; // High for one cycle when the result is ready.
        logic [11:0] data; // Raw 12-bit conversion result.
    } conv_result_t;

    // Control lines driven toward the analog converter.
    typedef struct packed {
        logic enable; // Converter powered up.
        logic track; // Input sample stage tracking.
        logic start; // One-cycle conversion request.
    } conv_ctrl_t;

    // A formatted result word as seen in the high and low byte registers.
    typedef struct packed {
        logic [7:0] high; // Upper byte.
        logic [7:0] low; // Lower byte.
    } data_word_t;

endpackage

/* src/adc_window_compare.sv */
// Result justification and window comparison for one conversion result.
`timescale 1ns/1ps

module adc_window_compare (
    input wire logic [11:0] raw, // Raw 12-bit conversion result.
    input wire logic justify, // Zero selects right, one left justify.
    input wire logic [15:0] gt_word, // Greater-than limit word.
    input wire logic [15:0] lt_word, // Less-than limit word.
    output adc_window_pkg::data_word_t word, // Formatted result word.
    output logic match // Result lies in the selected region.
);

    // Format the result; right justified data sign-extends bit 11.
    always_comb begin
        if (justify) begin
            word.high = raw[11:4];
            word.low = {raw[3:0], 4'h0};
        end else begin
            word.high = {{4{raw[11]}}, raw[11:8]};
            word.low = raw[7:0];
        end
    end

    // The limits are compared with the word exactly as software reads it.
    // The relative order of the two limits picks inside or outside.
    always_comb begin
        if (gt_word < lt_word) begin
            // Inside window: strictly between the limits.
            match = (word > gt_word) && (word < lt_word);
        end else begin
            // Outside window: above greater-than or below less-than.
            match = (word > gt_word) || (word < lt_word);
        end
    end

endmodule // adc_window_compare

/* verif/adc_result_window_detector_chk.sv */
// Port-level assertions for the converter window block.
`timescale 1ns/1ps

module adc_result_window_detector_chk (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Reset, active low.
    input wire logic s_axi_awvalid, // Write address valid.
    input wire logic s_axi_awready, // Write address ready.
    input wire logic s_axi_wvalid, // Write data valid.
    input wire logic s_axi_wready, // Write data ready.
    input wire logic [1:0] s_axi_bresp, // Write response.
    input wire logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic s_axi_arvalid, // Read address valid.
    input wire logic s_axi_arready, // Read address ready.
    input wire logic [31:0] s_axi_rdata, // Read data.
    input wire logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire adc_window_pkg::conv_result_t conv_result, // Result in.
    input wire adc_window_pkg::conv_ctrl_t conv_ctrl, // Converter lines.
    input wire logic irq // Interrupt request.
);
    // One clock domain, so one default clock and reset for all checks.
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_shutdown_idle: assert property (
        !conv_ctrl.enable |-> !conv_ctrl.start && !conv_ctrl.track)
        else $error("converter active while disabled");
    chk_busy_no_track: assert property (
        conv_ctrl.start && !conv_result.valid
        |=> !conv_ctrl.start && !conv_ctrl.track)
        else $error("tracking or second start during conversion");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    chk_read_byte: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_write_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    // A flag only falls by a software write, so irq may fall only after one.
    chk_irq_sticky: assert property (
        $fell(irq) |-> !$past(aresetn) || $past(s_axi_wvalid)
        || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
        else $error("interrupt fell without a write");
    chk_irq_cause: assert property (
        $rose(irq) |-> $past(conv_result.valid) || $past(s_axi_wvalid)
        || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
        else $error("interrupt rose without a result or write");

    // Main scenarios reached.
    cover property (conv_ctrl.start);
    cover property ($rose(irq));
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // adc_result_window_detector_chk

bind adc_result_window_detector adc_result_window_detector_chk
    adc_result_window_detector_chk_i (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .conv_result, .conv_ctrl,
    .irq);

/* verif/adc_result_window_detector_tb.sv */
// Self-checking bench for the converter window block.
`timescale 1ns/1ps
`include "adc_window_regs.svh"

module adc_result_window_detector_tb;
    logic aclk = 1'b0; // System clock.
    logic aresetn = 1'b0; // Reset, active low.
    logic [11:0] s_axi_awaddr = 12'h000; // Write address.
    logic s_axi_awvalid = 1'b0; // Write address valid.
    logic s_axi_awready; // Write address ready.
    logic [31:0] s_axi_wdata = 32'h00000000; // Write data.
    logic [3:0] s_axi_wstrb = 4'hF; // All byte lanes written.
    logic s_axi_wvalid = 1'b0; // Write data valid.
    logic s_axi_wready; // Write data ready.
    logic [1:0] s_axi_bresp; // Write response.
    logic s_axi_bvalid; // Write response valid.
    logic s_axi_bready = 1'b0; // Write response ready.
    logic [11:0] s_axi_araddr = 12'h000; // Read address.
    logic s_axi_arvalid = 1'b0; // Read address valid.
    logic s_axi_arready; // Read address ready.
    logic [31:0] s_axi_rdata; // Read data.
    logic [1:0] s_axi_rresp; // Read response.
    logic s_axi_rvalid; // Read data valid.
    logic s_axi_rready = 1'b0; // Read data ready.
    adc_window_pkg::conv_result_t conv_result = '0; // Converter result.
    adc_window_pkg::conv_ctrl_t conv_ctrl; // Converter lines.
    logic irq; // Interrupt request.
    logic [15:0] lfsr = 16'h8F36; // Random source state.
    logic [33:0] exp_q[$]; // Noted {resp, data} per bus answer.
    logic [33:0] exp_e; // Oldest note, being compared.
    logic [15:0] g, l, w; // Limits and sample of one window case.
    int n_fail = 0; // Mismatches.
    int n_tests = 0; // Comparisons.
    logic [7:0] rst_idx[8] = '{`IDX_RESULT_HIGH, `IDX_RESULT_LOW,
        `IDX_LT_LOW, `IDX_LT_HIGH, `IDX_GT_LOW, `IDX_GT_HIGH, `IDX_CONTROL,
        `IDX_IRQ_MASK}; // Registers with a known reset value.
    logic [7:0] rst_val[8] = '{`RST_BYTE, `RST_BYTE, `RST_LT_LOW,
        `RST_LT_HIGH, `RST_GT_LOW, `RST_GT_HIGH, 8'h00, 8'h00};
    // Window cases {gt, lt, sample}: inside band, then outside band.
    logic [47:0] win_tab[6] = '{48'h0100_0200_0101, 48'h0100_0200_0200,
        48'h0100_0200_0100, 48'h0200_0100_0201, 48'h0200_0100_00FF,
        48'h0200_0100_0100};

    adc_result_window_detector adc_result_window_detector_i (.aclk,
        .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .conv_result, .conv_ctrl, .irq);

    // Free-running 4 ns clock.
    initial begin
        forever #2 aclk = ~aclk;
    end

    // Next pseudo-random word; taps give a maximal sequence.
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // Expected match: between limits if gt < lt, else outside them.
    function automatic logic win_exp(input logic [15:0] gv, lv, wv);
        return (gv < lv) ? (wv > gv && wv < lv) : (wv > gv || wv < lv);
    endfunction

    task automatic chk(input logic [31:0] seen, exp, input string name);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One write; address and data offered together, each dropped once taken.
    task automatic wr(input logic [7:0] idx, d, input logic [1:0] resp);
        int n;
        exp_q.push_back({resp, 32'h00000000});
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {8'h00, rnd(), d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        // The extra edge keeps bready from being driven twice in one step.
        @(posedge aclk);
        if (n >= 50) begin
            n_fail++;
            end_sim();
        end
    endtask

    // One read; the watcher below compares the answer with the note.
    task automatic rd(input logic [7:0] idx, d, input logic [1:0] resp);
        int n;
        exp_q.push_back({resp, 24'h000000, d});
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (n >= 50) begin
            n_fail++;
            end_sim();
        end
    endtask

    // Start a conversion and deliver one result pulse while busy.
    task automatic conv(input logic j, input logic [11:0] d);
        wr(`IDX_CONTROL, 8'hB2 | {7'h00, j}, `RESP_OKAY);
        chk(32'(conv_ctrl), 32'h4, "conv_ctrl");
        conv_result <= {1'b1, d};
        @(posedge aclk);
        conv_result <= {1'b0, 12'(rnd())};
        @(posedge aclk);
        chk(32'(conv_ctrl), 32'h6, "conv_ctrl");
    endtask

    // Response watcher: each answer retires the oldest noted expectation.
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            exp_e = exp_q.pop_front();
            chk(32'(s_axi_bresp), 32'(exp_e[33:32]), "bresp");
        end
        if (s_axi_rvalid && s_axi_rready) begin
            exp_e = exp_q.pop_front();
            chk(s_axi_rdata, exp_e[31:0], "rdata");
            chk(32'(s_axi_rresp), 32'(exp_e[33:32]), "rresp");
        end
    end

    // Main sequence.
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        chk(32'(conv_ctrl), 32'h0, "conv_ctrl");
        foreach (rst_idx[i]) rd(rst_idx[i], rst_val[i], `RESP_OKAY);
        w = rnd();
        wr(`IDX_LT_HIGH, w[15:8], `RESP_OKAY);
        wr(`IDX_LT_LOW, w[7:0], `RESP_OKAY);
        rd(`IDX_LT_HIGH, w[15:8], `RESP_OKAY);
        rd(`IDX_LT_LOW, w[7:0], `RESP_OKAY);
        // An unmapped place refuses both directions.
        wr(8'h00, 8'h5A, `RESP_SLVERR);
        rd(8'h00, 8'h00, `RESP_SLVERR);
        wr(`IDX_CONTROL, 8'hC0, `RESP_OKAY);
        chk(32'(conv_ctrl), 32'h4, "conv_ctrl");
        for (int j = 0; j < 2; j++) begin
            w = rnd();
            conv(j[0], w[11:0]);
            rd(`IDX_RESULT_HIGH, j[0] ? w[11:4] : {{4{w[11]}}, w[11:8]},
                `RESP_OKAY);
            rd(`IDX_RESULT_LOW, j[0] ? {w[3:0], 4'h0} : w[7:0],
                `RESP_OKAY);
        end
        wr(`IDX_IRQ_MASK, 8'h02, `RESP_OKAY);
        foreach (win_tab[i]) begin
            {g, l, w} = win_tab[i];
            wr(`IDX_GT_HIGH, g[15:8], `RESP_OKAY);
            wr(`IDX_GT_LOW, g[7:0], `RESP_OKAY);
            wr(`IDX_LT_HIGH, l[15:8], `RESP_OKAY);
            wr(`IDX_LT_LOW, l[7:0], `RESP_OKAY);
            wr(`IDX_CONTROL, 8'h80, `RESP_OKAY);
            conv(1'b0, w[11:0]);
            rd(`IDX_CONTROL, {6'h28, win_exp(g, l, w), 1'b0},
                `RESP_OKAY);
            chk(32'(irq), 32'(win_exp(g, l, w)), "irq");
        end
        // A later miss must leave an earlier match standing.
        conv(1'b0, 12'h201);
        conv(1'b0, 12'h150);
        rd(`IDX_CONTROL, 8'hA2, `RESP_OKAY);
        rd(`IDX_IRQ_STATUS, 8'h03, `RESP_OKAY);
        wr(`IDX_IRQ_MASK, 8'h00, `RESP_OKAY);
        chk(32'(irq), 32'h0, "irq");
        wr(`IDX_IRQ_MASK, 8'h02, `RESP_OKAY);
        chk(32'(irq), 32'h1, "irq");
        wr(`IDX_IRQ_STATUS, 8'h02, `RESP_OKAY);
        chk(32'(irq), 32'h0, "irq");
        // Disabled converter ignores a start request.
        wr(`IDX_CONTROL, 8'h10, `RESP_OKAY);
        chk(32'(conv_ctrl), 32'h0, "conv_ctrl");
        rd(`IDX_CONTROL, 8'h00, `RESP_OKAY);
        end_sim();
    end
endmodule // adc_result_window_detector_tb
